// ==== design/fxa_pkg.sv ====
// fxa_pkg: register map, field positions, op codes and constants of the
// fixed/floating arithmetic datapath.
// assumes a 32-bit APB slave with byte addresses on an 8-bit paddr.
package fxa_pkg;
    localparam logic [7:0] OFF_OPA0 = 8'h00;
    localparam logic [7:0] OFF_OPA1 = 8'h04;
    localparam logic [7:0] OFF_OPA2 = 8'h08;
    localparam logic [7:0] OFF_OPB0 = 8'h0C;
    localparam logic [7:0] OFF_OPB1 = 8'h10;
    localparam logic [7:0] OFF_OPB2 = 8'h14;
    localparam logic [7:0] OFF_CTRL = 8'h18;
    localparam logic [7:0] OFF_RES0 = 8'h1C;
    localparam logic [7:0] OFF_RES1 = 8'h20;
    localparam logic [7:0] OFF_RES2 = 8'h24;
    localparam logic [7:0] OFF_FLAGS = 8'h28;
    localparam logic [7:0] OFF_INSTR_HI = 8'h2C;
    localparam logic [7:0] OFF_INSTR_LO = 8'h30;
    localparam logic [7:0] OFF_DECODE = 8'h34;
    localparam logic [7:0] OFF_SHCNT = 8'h38;
    localparam logic [7:0] OFF_MODE = 8'h3C;
    localparam logic [7:0] OFF_BASE = 8'h40;
    localparam logic [7:0] OFF_PADDR = 8'h44;
    localparam logic [7:0] OFF_AADDR = 8'h48;
    // control word fields
    localparam int CTRL_OP_LSB = 0;
    localparam int CTRL_PREC_LSB = 4;
    localparam logic [3:0] OP_ADDL = 4'h0;
    localparam logic [3:0] OP_SUBL = 4'h1;
    localparam logic [3:0] OP_CMPL = 4'h2;
    localparam logic [3:0] OP_ADDA = 4'h3;
    localparam logic [3:0] OP_SUBA = 4'h4;
    localparam logic [3:0] OP_CMPA = 4'h5;
    localparam logic [3:0] OP_MULI = 4'h6;
    localparam logic [3:0] OP_MULF = 4'h7;
    localparam logic [3:0] OP_DIVI = 4'h8;
    localparam logic [3:0] OP_DIVF = 4'h9;
    localparam logic [3:0] OP_FADD = 4'hA;
    localparam logic [3:0] OP_FSUB = 4'hB;
    localparam logic [3:0] OP_FNORM = 4'hC;
    localparam logic [1:0] PREC_HALF = 2'h0;
    localparam logic [1:0] PREC_SGL = 2'h1;
    localparam logic [1:0] PREC_DBL = 2'h2;
    // flag register bit positions
    localparam int FL_ZERO = 0;
    localparam int FL_NEG = 1;
    localparam int FL_CARRY = 2;
    localparam int FL_OVF = 3;
    localparam int FL_ABOVE = 4;
    localparam int FL_BELOW = 5;
    localparam int FL_DIVCHK = 6;
    localparam int FL_EXPERR = 7;
    // instruction word, index 35 is the leftmost machine bit
    localparam int IW_Y_LSB = 18;
    localparam int IW_OPC_LSB = 9;
    localparam int IW_INH = 7;
    localparam int IW_TAG_LSB = 0;
    localparam logic [2:0] SHIFT_CLASS = 3'h7;
    // relocation: upper nine address bits, two base bits tied low
    localparam int REL_LSB = 9;
    localparam logic [17:0] BASE_MASK = 18'h3FDFE;
    // floating point exponent limits and canonical zero exponent
    localparam logic [7:0] FEXP_ZERO = 8'h80;
    localparam logic signed [9:0] EXP_MAX = 10'sh07F;
    localparam logic signed [9:0] EXP_MIN = 10'sh380;
    localparam logic [71:0] RST_WORD = 72'h0;
endpackage

// ==== design/fxa_addw.sv ====
// fxa_addw: two's complement adder/subtractor of parameter width.
// assumes the caller selects the width that matches the precision.
`timescale 1ns/1ps
module fxa_addw #(
    parameter int W = 36
) (
    input wire logic [W-1:0] a,
    input wire logic [W-1:0] b,
    input wire logic sub,
    output logic [W-1:0] sum,
    output logic cout,
    output logic ovf,
    output logic zero,
    output logic neg
);
    logic [W-1:0] bx;
    logic c_sign;
    // subtraction adds the complement plus one, even for b == 0
    assign bx = sub ? ~b : b;
    assign {c_sign, sum[W-2:0]} = {1'b0, a[W-2:0]} + {1'b0, bx[W-2:0]}
        + {{(W-1){1'b0}}, sub};
    assign {cout, sum[W-1]} = {1'b0, a[W-1]} + {1'b0, bx[W-1]}
        + {1'b0, c_sign};
    assign ovf = c_sign ^ cout;
    assign zero = (sum == '0);
    assign neg = sum[W-1];
endmodule // fxa_addw

// ==== design/fxa_norm.sv ====
// fxa_norm: floating point normaliser with canonical zero.
// assumes a 66-bit mantissa: two guard sign bits over a 64-bit fraction.
`timescale 1ns/1ps
module fxa_norm
    import fxa_pkg::*;
(
    input wire logic [65:0] mant_in,
    input wire logic [9:0] exp_in,
    output logic [63:0] mant_out,
    output logic [7:0] exp_out,
    output logic zero,
    output logic exp_err
);
    logic [6:0] lz;
    logic run;
    logic [65:0] sh;
    logic signed [9:0] en;
    always_comb begin
        lz = 7'h00;
        run = 1'b1;
        for (int i = 64; i >= 0; i--) begin
            if (run && mant_in[i] == mant_in[65]) begin
                lz = lz + 7'h01;
            end else begin
                run = 1'b0;
            end
        end
        // two redundant sign bits sit above the normalised sign
        if (lz >= 7'h02) begin
            sh = mant_in << (lz - 7'h02);
        end else begin
            sh = $signed(mant_in) >>> (7'h02 - lz);
        end
        en = $signed(exp_in + 10'h002 - {3'h0, lz});
        zero = (mant_in == '0);
        exp_err = !zero && (en > EXP_MAX || en < EXP_MIN);
        mant_out = zero ? 64'h0 : sh[63:0];
        exp_out = zero ? FEXP_ZERO : en[7:0];
    end
endmodule // fxa_norm

// ==== design/fxa_core.sv ====
// fxa_core: APB-mapped arithmetic datapath with instruction field
// decode and program address translation.
// assumes an APB master on pclk; one wait state on every transfer.
`timescale 1ns/1ps
// Operation
// - unsigned add: carry out of the top bit means above range
// - unsigned subtract: no carry out of the top bit means below range
// - unsigned compare reports ordering through zero and carry flags
// - signed values: leftmost bit is sign, negatives in two's complement
// - signed add/subtract overflow when carry into sign differs from out
// - on signed overflow, sign 0 is below range, sign 1 above
// - integer multiply/divide put binary point right of the last bit
// - fractional multiply/divide put binary point right of the sign
// - fixed point works on 18, 36 and 72 bit operands; the code multiplies and divides on 36 bits only
// - float: 8-bit exponent over 28 or 64 bit signed mantissa
// - float add/subtract aligns the operand with smaller exponent
// - an all-zero untruncated float mantissa forces exponent -128
// - normalise by left shift until the leading bit differs from sign
// - instruction bits 27 and 29 are ignored and kept zero by software
// - shift instructions read the address field as the shift count
// - one instruction bit inhibits program interrupt recognition
// - slave mode addresses are translated before memory access
// - master mode addresses go to memory unchanged
// - relocation adds base upper bits, granularity 1024 words
module fxa_core
    import fxa_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [17:0] mem_addr,
    output logic mem_req,
    output logic intr_inhibit
);
    logic pready_r, pslverr_r, mem_req_r, intr_inhibit_r, slave_r;
    logic [31:0] prdata_r, rd_nxt;
    logic [71:0] opa_r, opb_r, res_r, res_nxt;
    logic [7:0] flags_r, flg_nxt;
    logic [5:0] ctrl_r;
    logic [35:0] instr_r;
    logic [17:0] base_r, paddr_r, mem_addr_r;
    logic mapped, acc, wr, go;
    logic [3:0] op_w;
    logic [1:0] pr_w;

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign mem_addr = mem_addr_r;
    assign mem_req = mem_req_r;
    assign intr_inhibit = intr_inhibit_r;

    // a write lands only at the edge where the master sees pready high
    assign acc = psel & penable & pready_r;
    assign wr = acc & pwrite & mapped;
    assign go = wr & (paddr == OFF_CTRL);
    assign op_w = pwdata[CTRL_OP_LSB +: 4];
    assign pr_w = pwdata[CTRL_PREC_LSB +: 2];

    // decoded instruction fields; decode skips bits at index 8 and 6, which only the OFF_INSTR_LO readback returns
    logic [8:0] opc;
    logic is_shift;
    assign opc = instr_r[IW_OPC_LSB +: 9];
    assign is_shift = (opc[8:6] == SHIFT_CLASS);

    always_comb begin
        mapped = 1'b1;
        rd_nxt = 32'h0;
        case (paddr)
            OFF_OPA0: rd_nxt = opa_r[31:0];
            OFF_OPA1: rd_nxt = opa_r[63:32];
            OFF_OPA2: rd_nxt = {24'h0, opa_r[71:64]};
            OFF_OPB0: rd_nxt = opb_r[31:0];
            OFF_OPB1: rd_nxt = opb_r[63:32];
            OFF_OPB2: rd_nxt = {24'h0, opb_r[71:64]};
            OFF_CTRL: rd_nxt = {26'h0, ctrl_r};
            OFF_RES0: rd_nxt = res_r[31:0];
            OFF_RES1: rd_nxt = res_r[63:32];
            OFF_RES2: rd_nxt = {24'h0, res_r[71:64]};
            OFF_FLAGS: rd_nxt = {24'h0, flags_r};
            OFF_INSTR_HI: rd_nxt = {14'h0, instr_r[35:18]};
            OFF_INSTR_LO: rd_nxt = {14'h0, instr_r[17:0]};
            OFF_DECODE: rd_nxt = {15'h0, is_shift,
                instr_r[IW_TAG_LSB +: 6], instr_r[IW_INH], opc};
            OFF_SHCNT: rd_nxt = is_shift ?
                {14'h0, instr_r[IW_Y_LSB +: 18]} : 32'h0;
            OFF_MODE: rd_nxt = {31'h0, slave_r};
            OFF_BASE: rd_nxt = {14'h0, base_r};
            OFF_PADDR: rd_nxt = {14'h0, paddr_r};
            OFF_AADDR: rd_nxt = {14'h0, mem_addr_r};
            default: mapped = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0;
        end else begin
            pready_r <= psel & penable & ~pready_r;
            pslverr_r <= psel & penable & ~pready_r & ~mapped;
            if (psel & penable & ~pready_r & ~pwrite) begin
                prdata_r <= rd_nxt;
            end
        end
    end

    // operand words: the top word carries only eight bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            opa_r <= RST_WORD;
            opb_r <= RST_WORD;
        end else if (wr) begin
            case (paddr)
                OFF_OPA0: opa_r[31:0] <= pwdata;
                OFF_OPA1: opa_r[63:32] <= pwdata;
                OFF_OPA2: opa_r[71:64] <= pwdata[7:0];
                OFF_OPB0: opb_r[31:0] <= pwdata;
                OFF_OPB1: opb_r[63:32] <= pwdata;
                OFF_OPB2: opb_r[71:64] <= pwdata[7:0];
                default: ;
            endcase
        end
    end

    // adders per precision
    logic [17:0] s18;
    logic [35:0] s36;
    logic [71:0] s72;
    logic [2:0] co, ov, zr, ng;
    logic sub_w;
    assign sub_w = (op_w == OP_SUBL) | (op_w == OP_CMPL) |
        (op_w == OP_SUBA) | (op_w == OP_CMPA);
    fxa_addw #(.W(18)) u_add18 (.a(opa_r[17:0]), .b(opb_r[17:0]),
        .sub(sub_w), .sum(s18), .cout(co[0]), .ovf(ov[0]),
        .zero(zr[0]), .neg(ng[0]));
    fxa_addw #(.W(36)) u_add36 (.a(opa_r[35:0]), .b(opb_r[35:0]),
        .sub(sub_w), .sum(s36), .cout(co[1]), .ovf(ov[1]),
        .zero(zr[1]), .neg(ng[1]));
    fxa_addw #(.W(72)) u_add72 (.a(opa_r), .b(opb_r),
        .sub(sub_w), .sum(s72), .cout(co[2]), .ovf(ov[2]),
        .zero(zr[2]), .neg(ng[2]));

    logic [71:0] s_sum;
    logic s_co, s_ov, s_z, s_n;
    always_comb begin
        case (pr_w)
            PREC_HALF: begin
                s_sum = {54'h0, s18};
                {s_co, s_ov, s_z, s_n} = {co[0], ov[0], zr[0], ng[0]};
            end
            PREC_DBL: begin
                s_sum = s72;
                {s_co, s_ov, s_z, s_n} = {co[2], ov[2], zr[2], ng[2]};
            end
            default: begin
                s_sum = {36'h0, s36};
                {s_co, s_ov, s_z, s_n} = {co[1], ov[1], zr[1], ng[1]};
            end
        endcase
    end

    // single precision multiply and divide on the low operand words
    logic signed [71:0] prod, dvd_f, dvs_f, qf;
    logic signed [35:0] dvs, qi, ri;
    logic bzero, dmin;
    assign prod = $signed({{36{opa_r[35]}}, opa_r[35:0]}) *
        $signed({{36{opb_r[35]}}, opb_r[35:0]});
    assign bzero = (opb_r[35:0] == 36'h0);
    // divisor of zero would give unknowns, so divide by one and flag it
    assign dvs = bzero ? 36'sh000000001 : $signed(opb_r[35:0]);
    assign dmin = (opa_r[35:0] == 36'h800000000) & (&opb_r[35:0]);
    assign qi = dmin ? 36'sh0 : $signed(opa_r[35:0]) / dvs;
    assign ri = dmin ? 36'sh0 : $signed(opa_r[35:0]) % dvs;
    assign dvd_f = $signed({opa_r[35], opa_r[35:0], 35'h0});
    assign dvs_f = $signed({{36{dvs[35]}}, dvs});
    assign qf = dvd_f / dvs_f;

    // floating add/subtract: align smaller exponent, then normalise
    logic [63:0] fa64, fb64, nm;
    logic [65:0] fma, fmb, big, sml, fsum, n_in;
    logic [8:0] ed;
    logic [7:0] fe, ne, shamt;
    logic nz, nerr, fop;
    assign fop = (op_w == OP_FADD) | (op_w == OP_FSUB);
    assign fa64 = (pr_w == PREC_DBL) ? opa_r[63:0] :
        {opa_r[63:36], 36'h0};
    assign fb64 = (pr_w == PREC_DBL) ? opb_r[63:0] :
        {opb_r[63:36], 36'h0};
    assign fma = {{2{fa64[63]}}, fa64};
    assign fmb = (op_w == OP_FSUB) ? 66'h0 - {{2{fb64[63]}}, fb64} :
        {{2{fb64[63]}}, fb64};
    assign ed = {opa_r[71], opa_r[71:64]} - {opb_r[71], opb_r[71:64]};
    always_comb begin
        if (ed[8]) begin
            big = fmb;
            sml = fma;
            fe = opb_r[71:64];
            shamt = 8'h0 - ed[7:0];
        end else begin
            big = fma;
            sml = fmb;
            fe = opa_r[71:64];
            shamt = ed[7:0];
        end
        fsum = big + 66'($signed(sml) >>> shamt);
        n_in = fop ? fsum : fma;
    end
    fxa_norm u_norm (.mant_in(n_in),
        .exp_in(fop ? {{2{fe[7]}}, fe} : {{2{opa_r[71]}}, opa_r[71:64]}),
        .mant_out(nm), .exp_out(ne), .zero(nz), .exp_err(nerr));

    always_comb begin
        res_nxt = res_r;
        flg_nxt = 8'h0;
        case (op_w)
            OP_ADDL, OP_SUBL, OP_CMPL: begin
                flg_nxt[FL_ZERO] = s_z;
                flg_nxt[FL_NEG] = s_n;
                flg_nxt[FL_CARRY] = s_co;
                flg_nxt[FL_ABOVE] = (op_w == OP_ADDL) & s_co;
                flg_nxt[FL_BELOW] = (op_w == OP_SUBL) & ~s_co;
                if (op_w != OP_CMPL) res_nxt = s_sum;
            end
            OP_ADDA, OP_SUBA, OP_CMPA: begin
                flg_nxt[FL_ZERO] = s_z;
                flg_nxt[FL_NEG] = s_n;
                flg_nxt[FL_CARRY] = s_co;
                flg_nxt[FL_OVF] = s_ov;
                flg_nxt[FL_ABOVE] = s_ov & s_n;
                flg_nxt[FL_BELOW] = s_ov & ~s_n;
                if (op_w != OP_CMPA) res_nxt = s_sum;
            end
            OP_MULI, OP_MULF: begin
                // fraction product drops the doubled sign bit
                res_nxt = (op_w == OP_MULI) ? prod :
                    {prod[70:0], 1'b0};
                flg_nxt[FL_OVF] = (op_w == OP_MULF) & (prod[71] ^ prod[70]);
                flg_nxt[FL_ZERO] = (prod == 72'sh0);
                flg_nxt[FL_NEG] = prod[71];
            end
            OP_DIVI, OP_DIVF: begin
                res_nxt = (op_w == OP_DIVI) ? {qi, ri} :
                    {qf[35:0], 36'h0};
                flg_nxt[FL_DIVCHK] = bzero | ((op_w == OP_DIVI) ? dmin :
                    ~((&qf[71:35]) | ~(|qf[71:35])));
                flg_nxt[FL_ZERO] = (res_nxt == 72'h0);
                flg_nxt[FL_NEG] = res_nxt[71];
            end
            OP_FADD, OP_FSUB, OP_FNORM: begin
                res_nxt = {ne, (pr_w == PREC_DBL) ? nm :
                    {nm[63:36], 36'h0}};
                flg_nxt[FL_ZERO] = nz;
                flg_nxt[FL_NEG] = nm[63];
                flg_nxt[FL_OVF] = nerr;
                flg_nxt[FL_EXPERR] = nerr;
            end
            default: ;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= 6'h0;
            res_r <= RST_WORD;
            flags_r <= 8'h0;
        end else if (go) begin
            ctrl_r <= pwdata[5:0];
            res_r <= res_nxt;
            flags_r <= flg_nxt;
        end
    end

    // instruction word; decode of the low half also sets the inhibit pin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            instr_r <= 36'h0;
            intr_inhibit_r <= 1'b0;
        end else if (wr && paddr == OFF_INSTR_HI) begin
            instr_r[35:18] <= pwdata[17:0];
        end else if (wr && paddr == OFF_INSTR_LO) begin
            instr_r[17:0] <= pwdata[17:0];
            intr_inhibit_r <= pwdata[IW_INH];
        end
    end

    // mode, base and translated memory requests
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slave_r <= 1'b0;
            base_r <= 18'h0;
            paddr_r <= 18'h0;
            mem_addr_r <= 18'h0;
            mem_req_r <= 1'b0;
        end else begin
            mem_req_r <= 1'b0;
            if (wr && paddr == OFF_MODE) slave_r <= pwdata[0];
            if (wr && paddr == OFF_BASE) begin
                base_r <= pwdata[17:0] & BASE_MASK;
            end
            if (wr && paddr == OFF_PADDR) begin
                paddr_r <= pwdata[17:0];
                mem_req_r <= 1'b1;
                if (slave_r) begin
                    mem_addr_r <= {9'(pwdata[17:REL_LSB] +
                        base_r[17:REL_LSB]), pwdata[REL_LSB-1:0]};
                end else begin
                    mem_addr_r <= pwdata[17:0];
                end
            end
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    property p_ul_add;
        go && op_w == OP_ADDL && pr_w == PREC_SGL |=> flags_r[FL_ABOVE] ==
        (({1'b0, $past(opa_r[35:0])} + {1'b0, $past(opb_r[35:0])})
        > 37'h0FFFFFFFFF);
    endproperty
    a_ul_add: assert property (p_ul_add) else $error("add above");
    property p_ul_sub;
        go && op_w == OP_SUBL && pr_w == PREC_SGL |=> flags_r[FL_BELOW] ==
        ($past(opa_r[35:0]) < $past(opb_r[35:0]));
    endproperty
    a_ul_sub: assert property (p_ul_sub) else $error("sub below");
    property p_ul_cmp;
        go && op_w == OP_CMPL && pr_w == PREC_SGL |=>
        flags_r[FL_ZERO] == ($past(opa_r[35:0]) == $past(opb_r[35:0])) &&
        flags_r[FL_CARRY] == ($past(opa_r[35:0]) >= $past(opb_r[35:0]));
    endproperty
    a_ul_cmp: assert property (p_ul_cmp) else $error("compare");
    property p_sg_ovf;
        go && op_w == OP_ADDA && pr_w == PREC_SGL |=> flags_r[FL_OVF] ==
        ($past(opa_r[35]) == $past(opb_r[35]) &&
        res_r[35] != $past(opa_r[35]));
    endproperty
    a_sg_ovf: assert property (p_sg_ovf) else $error("ovf");
    property p_sg_range;
        go && op_w == OP_SUBA |=>
        !flags_r[FL_OVF] || (flags_r[FL_BELOW] != flags_r[FL_NEG]);
    endproperty
    a_sg_range: assert property (p_sg_range) else $error("range");
    property p_mul_int;
        go && op_w == OP_MULI |=> $signed(res_r) ==
        $signed($past(opa_r[35:0])) * $signed($past(opb_r[35:0]));
    endproperty
    a_mul_int: assert property (p_mul_int) else $error("mul");
    property p_fzero;
        go && fop ##1 flags_r[FL_ZERO] |->
        res_r[71:64] == FEXP_ZERO && res_r[63:0] == 64'h0;
    endproperty
    a_fzero: assert property (p_fzero) else $error("fzero");
    property p_slave;
        wr && paddr == OFF_PADDR && slave_r |=> mem_req_r &&
        mem_addr_r[8:0] == $past(pwdata[8:0]) && mem_addr_r[17:9] ==
        9'($past(pwdata[17:9]) + $past(base_r[17:9]));
    endproperty
    a_slave: assert property (p_slave) else $error("xlate");
    property p_master;
        wr && paddr == OFF_PADDR && !slave_r |=>
        mem_req_r && mem_addr_r == $past(pwdata[17:0]) ##1 !mem_req_r;
    endproperty
    a_master: assert property (p_master) else $error("direct");
    property p_inhibit;
        wr && paddr == OFF_INSTR_LO |=>
        intr_inhibit_r == $past(pwdata[IW_INH]);
    endproperty
    a_inhibit: assert property (p_inhibit) else $error("inhibit");
    property p_apb;
        psel && penable && !pready_r |=> pready_r ##1 !pready_r;
    endproperty
    a_apb: assert property (p_apb) else $error("apb");
    c_fzero: cover property (go && fop ##1 flags_r[FL_ZERO]);
    c_divchk: cover property (go && op_w == OP_DIVI ##1 flags_r[FL_DIVCHK]);
    c_slave: cover property (wr && paddr == OFF_PADDR && slave_r);
endmodule // fxa_core

// ==== tb/test_fixed_float_arith_datapath.sv ====
// test_fixed_float_arith_datapath: self-checking bench for fxa_core.
// assumes an APB slave with one wait state and a memory request output.
`timescale 1ns/1ps
module test_fixed_float_arith_datapath
    import fxa_pkg::*;
;
logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
logic pwrite = 1'b0, pready, pslverr, mem_req, intr_inhibit, err;
logic sb, cy, ng, zr, ov, ab, bl;
logic [7:0] paddr = 8'h00, fl, mk;
logic [31:0] pwdata = 32'h0, prdata, q, q0, seed = 32'h85FD93A1;
logic [17:0] mem_addr, y, bs, ad;
logic [71:0] a, b, bb, r, m, e;
logic [72:0] s;
int fails = 0, n_tests = 0, wd;
longint x, z;
logic [3:0] ops [6] = '{OP_ADDL, OP_SUBL, OP_CMPL, OP_ADDA, OP_SUBA, OP_CMPA};
logic [1:0] prs [3] = '{PREC_SGL, PREC_HALF, PREC_DBL};
int wds [3] = '{36, 18, 72};
logic [35:0] fin [3] = '{{8'h07, 28'h0D00000}, {8'hFC, 28'hEB80000},
    {8'h05, 28'h0000000}};
logic [35:0] fout [3] = '{{8'h04, 28'h6800000}, {8'hFA, 28'hAE00000},
    {8'h80, 28'h0000000}};
always #25 pclk = ~pclk;
fxa_core i_fxa_core (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mem_addr(mem_addr), .mem_req(mem_req), .intr_inhibit(intr_inhibit));
function automatic logic [71:0] rnd();
    for (int i = 0; i < 3; i++) begin
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        rnd = {rnd[39:0], seed};
    end
endfunction
task automatic give_verdict;
    if (fails == 0 && n_tests > 0) begin
        $display("TB: PASS");
    end else begin
        $display("TB: FAIL");
    end
    $finish;
endtask
task automatic chk(input string nm, input logic [71:0] ex,
        input logic [71:0] got);
    n_tests++;
    if (got !== ex) begin
        fails++;
        $display("unexpected %s: expected %h, seen %h", nm, ex, got);
    end
endtask
// an idle edge follows each transfer so no signal is driven twice at once
task automatic apb(input logic w, input logic [7:0] pa, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= pa;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
        @(posedge pclk);
        k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) fails++;
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
endtask
task automatic opnd(input logic [7:0] pa, input logic [71:0] v);
    apb(1'b1, pa, v[31:0]);
    apb(1'b1, pa + 8'h04, v[63:32]);
    apb(1'b1, pa + 8'h08, {24'h0, v[71:64]});
endtask
task automatic run(input logic [3:0] op, input logic [1:0] pr);
    opnd(OFF_OPA0, a);
    opnd(OFF_OPB0, b);
    apb(1'b1, OFF_CTRL, {26'h0, pr, op});
    apb(1'b0, OFF_RES0, 32'h0);
    r[31:0] = q;
    apb(1'b0, OFF_RES1, 32'h0);
    r[63:32] = q;
    apb(1'b0, OFF_RES2, 32'h0);
    r[71:64] = q[7:0];
    apb(1'b0, OFF_FLAGS, 32'h0);
endtask
task automatic memchk(input logic [17:0] ex);
    int k;
    k = 0;
    while (mem_req !== 1'b1 && k < 5) begin
        @(posedge pclk);
        k++;
    end
    chk("mem_req", 72'h1, 72'(mem_req));
    chk("mem_addr", 72'(ex), 72'(mem_addr));
endtask
initial begin
    #1000000;
    fails++;
    give_verdict;
end
initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, OFF_FLAGS, 32'h0);
    chk("flags_rst", 72'h0, 72'(q));
    for (int p = 0; p < 3; p++) begin
        wd = wds[p];
        m = (wd == 72) ? {72{1'b1}} : ((72'h1 << wd) - 72'h1);
        for (int t = 0; t < 5; t++) begin
            for (int o = 0; o < 6; o++) begin
                a = rnd() & m;
                b = (t < 3) ? 72'h1 : (t == 3) ? a : rnd() & m;
                if (t == 0) a = m >> 1;
                if (t == 1) a = m;
                if (t == 2) a = 72'h0;
                run(ops[o], prs[p]);
                sb = (o % 3) != 0;
                bb = sb ? ~b & m : b;
                s = {1'b0, a} + {1'b0, bb} + 73'(sb);
                cy = s[wd];
                ng = s[wd-1];
                e = s[71:0] & m;
                zr = (e == 72'h0);
                ov = cy ^ s[wd-1] ^ a[wd-1] ^ bb[wd-1];
                ab = (o < 3) ? !sb & cy : ov & ng;
                bl = (o < 3) ? sb & !cy : ov & !ng;
                fl = {2'b00, bl, ab, ov, cy, ng, zr};
                mk = (o == 2) ? 8'h05 : (o == 5) ? 8'h01 :
                    (o < 3) ? 8'h35 : 8'h3F;
                chk("flags", 72'(fl & mk),
                    72'(q[7:0] & mk));
                if (o % 3 != 2) chk("sum", e, r & m);
            end
        end
    end
    for (int k = 0; k < 3; k++) begin
        a = rnd();
        b = rnd();
        if (k == 0) a[35:0] = 36'hFFFFFFFFF;
        e = {{36{a[35]}}, a[35:0]} * {{36{b[35]}}, b[35:0]};
        run(OP_MULI, PREC_SGL);
        chk("product", e, r);
        run(OP_MULF, PREC_SGL);
        chk("fraction", e << 1, r);
        a = {fin[k], 36'h0};
        run(OP_FNORM, PREC_SGL);
        chk("float", 72'(fout[k]), 72'(r[71:36]));
    end
    // integer divide against the bench's own signed division; the last pass divides by zero and checks only the flag
    for (int k = 0; k < 3; k++) begin
        a = rnd();
        b = rnd();
        if (k == 2) b[35:0] = 36'h0;
        x = $signed(a[35:0]);
        z = $signed(b[35:0]);
        run(OP_DIVI, PREC_SGL);
        if (k < 2) chk("quotient", {36'(x / z), 36'(x % z)}, r);
        else chk("divchk", 72'h1, 72'(q[FL_DIVCHK]));
    end
    // -1/8 divided by 1/2 gives -1/4 with the point after the sign
    a = 72'hF00000000;
    b = 72'h400000000;
    run(OP_DIVF, PREC_SGL);
    chk("fraction_q", {36'hE00000000, 36'h0}, r);
    // 0.5 * 2^1 + 0.5 * 2^0, once with each operand the smaller
    for (int k = 0; k < 2; k++) begin
        a = {8'(k == 0), 28'h4000000, 36'h0};
        b = {8'(k != 0), 28'h4000000, 36'h0};
        run(OP_FADD, PREC_SGL);
        chk("fadd", 72'({8'h01, 28'h6000000}), 72'(r[71:36]));
    end
    b = a;
    run(OP_FSUB, PREC_SGL);
    chk("fsub", {8'h80, 64'h0}, r);
    chk("fzero_flag", 72'h1, 72'(q[FL_ZERO]));
    for (int k = 0; k < 4; k++) begin
        {bs, ad} = 36'(rnd());
        apb(1'b1, OFF_MODE, {31'h0, k[1]});
        apb(1'b1, OFF_BASE, {14'h0, bs});
        apb(1'b0, OFF_BASE, 32'h0);
        chk("base", 72'(bs & BASE_MASK), 72'(q));
        bs = bs & BASE_MASK;
        apb(1'b1, OFF_PADDR, {14'h0, ad});
        memchk(k[1] ? {ad[17:9] + bs[17:9], ad[8:0]} :
            ad);
    end
    for (int k = 0; k < 2; k++) begin
        y = 18'(rnd());
        fl = 8'(rnd());
        apb(1'b1, OFF_INSTR_HI, {14'h0, y});
        apb(1'b1, OFF_INSTR_LO, {14'h0, k ? 9'h1C5 : 9'h0A3, 1'b1,
            k[0], 1'b1, fl[5:0]});
        apb(1'b0, OFF_DECODE, 32'h0);
        chk("decode", {55'h0, k[0], fl[5:0], k[0], k ? 9'h1C5 : 9'h0A3},
            72'(q));
        apb(1'b0, OFF_SHCNT, 32'h0);
        chk("shift", k ? 72'(y) : 72'h0, 72'(q));
        chk("inhibit", 72'(k[0]), 72'(intr_inhibit));
    end
    apb(1'b0, OFF_RES0, 32'h0);
    q0 = q;
    apb(1'b1, OFF_RES0, ~q0);
    apb(1'b0, OFF_RES0, 32'h0);
    chk("res_ro", 72'(q0), 72'(q));
    apb(1'b0, 8'hFC, 32'h0);
    chk("unmapped", 72'h100000000, {39'h0, err, q});
    give_verdict;
end
endmodule // test_fixed_float_arith_datapath
